/* File: dcr_chk.sv */
`timescale 1ns/1ps
module dcr_chk (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // register port
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // response stream
  input wire query_req,
  input wire [7:0] resp_data,
  input wire resp_valid,
  input wire resp_last,
  input wire resp_ready,
  // decoder steering
  input wire [7:0] decoder_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // read data only in the cycle after a read strobe
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  count_first_a: assert property ($rose(resp_valid) |-> resp_data == 8'h33)
    else $error("first byte is not the count");
  byte_hold_a: assert property (resp_valid && !resp_ready |=>
    resp_valid && $stable(resp_data) && $stable(resp_last)) else $error("byte not held");
  last_valid_a: assert property (resp_last |-> resp_valid)
    else $error("last without valid");
  dec_legal_a: assert property (decoder_sel inside {0, 1, 3, 5, 7, 9, 11, 14})
    else $error("illegal decoder code");
  dec_store_a: assert property (reg_wr && reg_addr == 6'h00 && !resp_valid && !query_req &&
    reg_wdata inside {0, 1, 3, 5, 7, 9, 11, 14} |-> ##2 decoder_sel == $past(reg_wdata, 2))
    else $error("decoder code not applied");
  resv_zero_a: assert property (reg_rd && reg_addr == 6'h16 |=> reg_rdata == 8'h00)
    else $error("reserved byte not zero");
  spare_two_a: assert property (reg_rd && reg_addr == 6'h12 |=> reg_rdata[7:6] == 2'b00)
    else $error("mask two spare bits set");
  spare_four_a: assert property (reg_rd && reg_addr == 6'h14 |=> reg_rdata[7:4] == 4'h0)
    else $error("mask four spare bits set");
  depth_legal_a: assert property (reg_rd && reg_addr == 6'h05 |=> reg_rdata inside {4, 8})
    else $error("bad interleaver depth");
  // main scenarios reached
  cover property (resp_valid && resp_last && resp_ready);
  cover property (resp_valid && !resp_ready);
  cover property (reg_wr && reg_addr == 6'h38);
endmodule // dcr_chk

bind dcr_config_record dcr_chk u_chk (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .query_req, .resp_data, .resp_valid, .resp_last, .resp_ready, .decoder_sel);

/* File: dcr_config_record.v */
`timescale 1ns/1ps
`include "dcr_consts.vh"

module dcr_config_record #(
  parameter CFG_BYTES = 51
) (
  // clock, reset, enable
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  // register port
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // query request from the protocol framer
  input wire query_req,
  // serial response byte stream
  output reg [7:0] resp_data,
  output reg resp_valid,
  output reg resp_last,
  input wire resp_ready,
  // field outputs steering the receive chain
  output reg [7:0] decoder_sel,
  output reg rs_enable,
  output reg descr_enable,
  output reg spectrum_inv,
  output reg test_mode,
  // interrupt
  output reg irq
);

  localparam ST_IDLE = 2'b00;
  localparam ST_COUNT = 2'b01;
  localparam ST_DATA = 2'b10;

  reg [7:0] cfg_mem [0:CFG_BYTES-1];
  reg [1:0] state_reg;
  reg [5:0] idx_reg;
  reg [2:0] status_reg;
  reg [2:0] irq_mask_reg;
  integer i;

  // legality of a written byte at a record offset
  function legal_byte;
    input [5:0] ofs;
    input [7:0] d;
    begin
      case (ofs)
        `DCR_OFS_DECODER:
          legal_byte = (d == `DCR_DEC_NONE) || (d == `DCR_DEC_VIT_12) ||
                       (d == `DCR_DEC_VIT_34) || (d == `DCR_DEC_VIT_78) ||
                       (d == `DCR_DEC_SEQ_12) || (d == `DCR_DEC_SEQ_34) ||
                       (d == `DCR_DEC_SEQ_78) || (d == `DCR_DEC_TRELLIS);
        `DCR_OFS_RS_DEPTH:
          legal_byte = (d == `DCR_DEPTH_4) || (d == `DCR_DEPTH_8);
        `DCR_OFS_RS_EN, `DCR_OFS_DESCR_CTL, `DCR_OFS_DIFF_DEC:
          legal_byte = (d <= `DCR_MAX_FLAG);
        `DCR_OFS_DESCR_TYPE:
          legal_byte = (d <= `DCR_DSC_V35_LAST) || (d == `DCR_DSC_RS) ||
                       (d == `DCR_DSC_V35_RS);
        `DCR_OFS_SPECTRUM, `DCR_OFS_BUF_POL:
          legal_byte = (d <= `DCR_MAX_FLAG);
        `DCR_OFS_BUF_CLK:
          legal_byte = (d <= `DCR_MAX_BUF_CLK);
        `DCR_OFS_OP_MODE:
          legal_byte = (d <= `DCR_MAX_FLAG);
        `DCR_OFS_LB_TERR, `DCR_OFS_LB_BASEBAND, `DCR_OFS_LB_IF:
          legal_byte = (d <= `DCR_MAX_FLAG);
        default:
          legal_byte = 1'b1;
      endcase
    end
  endfunction

  // spare bits of alarm masks are forced to zero on store
  function [7:0] store_value;
    input [5:0] ofs;
    input [7:0] d;
    begin
      case (ofs)
        `DCR_OFS_MASK1: store_value = d & `DCR_USE_MASK1;
        `DCR_OFS_MASK2: store_value = d & `DCR_USE_MASK2;
        `DCR_OFS_MASK3: store_value = d & `DCR_USE_MASK3;
        `DCR_OFS_MASK4: store_value = d & `DCR_USE_MASK4;
        `DCR_OFS_MASK_COMMON: store_value = d & `DCR_USE_COMMON;
        `DCR_OFS_RESERVED: store_value = `DCR_RST_BYTE;
        `DCR_OFS_BER_EXP: store_value = d;
        default: store_value = d;
      endcase
    end
  endfunction

  // reset value of each record byte
  function [7:0] reset_value;
    input [5:0] ofs;
    begin
      if (ofs == `DCR_OFS_RS_DEPTH) begin
        reset_value = `DCR_RST_DEPTH;
      end else begin
        reset_value = `DCR_RST_BYTE;
      end
    end
  endfunction

  wire in_record = (reg_addr <= `DCR_OFS_LAST);
  wire cfg_wr = reg_wr && in_record && (state_reg == ST_IDLE);
  wire wr_ok = legal_byte(reg_addr, reg_wdata);
  wire start_req = query_req ||
    (reg_wr && (reg_addr == `DCR_ADDR_CONTROL) && reg_wdata[`DCR_CTL_START]);
  wire advance = resp_valid && resp_ready;
  wire last_sent = advance && resp_last;
  // a write during a transfer, or an illegal code, is refused
  wire reject_evt = reg_wr && in_record && (!cfg_wr || !wr_ok);
  wire clr_wr = reg_wr && (reg_addr == `DCR_ADDR_STATUS);

  // record storage, written only when legal and idle
  always @(posedge mclk) begin
    if (!reset_n) begin
      for (i = 0; i < CFG_BYTES; i = i + 1) begin
        cfg_mem[i] <= reset_value(i[5:0]);
      end
    end else if (clk_en && cfg_wr && wr_ok) begin
      cfg_mem[reg_addr] <= store_value(reg_addr, reg_wdata);
    end
  end

  // field outputs taken straight from stored bytes
  always @(posedge mclk) begin
    if (!reset_n) begin
      decoder_sel <= `DCR_DEC_NONE;
      rs_enable <= 1'b0;
      descr_enable <= 1'b0;
      spectrum_inv <= 1'b0;
      test_mode <= 1'b0;
    end else if (clk_en) begin
      decoder_sel <= cfg_mem[`DCR_OFS_DECODER];
      rs_enable <= cfg_mem[`DCR_OFS_RS_EN][0];
      descr_enable <= cfg_mem[`DCR_OFS_DESCR_CTL][0];
      spectrum_inv <= cfg_mem[`DCR_OFS_SPECTRUM][0];
      test_mode <= cfg_mem[`DCR_OFS_OP_MODE][0];
    end
  end

  // response serialiser: count byte, then the record in order
  always @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      idx_reg <= 6'h00;
      resp_data <= 8'h00;
      resp_valid <= 1'b0;
      resp_last <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        ST_IDLE: begin
          if (start_req) begin
            resp_data <= `DCR_CFG_COUNT;
            resp_valid <= 1'b1;
            resp_last <= 1'b0;
            idx_reg <= 6'h00;
            state_reg <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (advance) begin
            resp_data <= cfg_mem[idx_reg];
            resp_last <= (idx_reg == `DCR_OFS_LAST);
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (advance) begin
            if (resp_last) begin
              resp_valid <= 1'b0;
              resp_last <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              resp_data <= cfg_mem[idx_reg + 6'h01];
              resp_last <= ((idx_reg + 6'h01) == `DCR_OFS_LAST);
              idx_reg <= idx_reg + 6'h01;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          resp_valid <= 1'b0;
          resp_last <= 1'b0;
        end
      endcase
    end
  end

  // sticky status, set wins over write-one-to-clear
  always @(posedge mclk) begin
    if (!reset_n) begin
      status_reg <= 3'b000;
      irq_mask_reg <= 3'b000;
    end else if (clk_en) begin
      status_reg[`DCR_ST_DONE] <= last_sent ||
        (status_reg[`DCR_ST_DONE] && !(clr_wr && reg_wdata[`DCR_ST_DONE]));
      status_reg[`DCR_ST_REJECT] <= reject_evt ||
        (status_reg[`DCR_ST_REJECT] && !(clr_wr && reg_wdata[`DCR_ST_REJECT]));
      status_reg[`DCR_ST_BUSY] <= (state_reg != ST_IDLE); // read-only busy view
      if (reg_wr && (reg_addr == `DCR_ADDR_IRQ_MASK)) begin
        irq_mask_reg <= reg_wdata[2:0];
      end
    end
  end

  // level interrupt from unmasked sticky bits
  always @(posedge mclk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(status_reg[1:0] & irq_mask_reg[1:0]);
    end
  end

  // read data, one cycle after the strobe only
  always @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd) begin
        if (in_record) begin
          reg_rdata <= cfg_mem[reg_addr];
        end else if (reg_addr == `DCR_ADDR_STATUS) begin
          reg_rdata <= {5'b00000, status_reg};
        end else if (reg_addr == `DCR_ADDR_IRQ_MASK) begin
          reg_rdata <= {5'b00000, irq_mask_reg};
        end else if (reg_addr == `DCR_ADDR_CONTROL) begin
          reg_rdata <= {7'b0000000, status_reg[`DCR_ST_BUSY]};
        end else begin
          reg_rdata <= 8'h00;
        end
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule // dcr_config_record

/* File: dcr_consts.vh */
`ifndef DCR_CONSTS_VH
`define DCR_CONSTS_VH

// record byte offsets, also the register addresses of the config bytes
`define DCR_OFS_DECODER 6'h00
`define DCR_OFS_RS_EN 6'h01
`define DCR_OFS_RS_N 6'h02
`define DCR_OFS_RS_K 6'h03
`define DCR_OFS_RS_T 6'h04
`define DCR_OFS_RS_DEPTH 6'h05
`define DCR_OFS_DIFF_DEC 6'h06
`define DCR_OFS_DESCR_CTL 6'h07
`define DCR_OFS_DESCR_TYPE 6'h08
`define DCR_OFS_SPECTRUM 6'h09
`define DCR_OFS_BUF_MS_HI 6'h0A
`define DCR_OFS_BUF_MS_LO 6'h0B
`define DCR_OFS_BUF_BY_HI 6'h0C
`define DCR_OFS_BUF_BY_LO 6'h0D
`define DCR_OFS_BUF_CLK 6'h0E
`define DCR_OFS_BUF_POL 6'h0F
`define DCR_OFS_OP_MODE 6'h10
`define DCR_OFS_MASK1 6'h11
`define DCR_OFS_MASK2 6'h12
`define DCR_OFS_MASK3 6'h13
`define DCR_OFS_MASK4 6'h14
`define DCR_OFS_MASK_COMMON 6'h15
`define DCR_OFS_RESERVED 6'h16
`define DCR_OFS_BER_EXP 6'h17
`define DCR_OFS_CIRCUIT_ID 6'h18
`define DCR_OFS_CIRCUIT_END 6'h2F
`define DCR_OFS_LB_TERR 6'h30
`define DCR_OFS_LB_BASEBAND 6'h31
`define DCR_OFS_LB_IF 6'h32
`define DCR_OFS_LAST 6'h32

// number of configuration bytes sent after the count byte
`define DCR_CFG_COUNT 8'h33

// block control and interrupt registers
`define DCR_ADDR_STATUS 6'h38
`define DCR_ADDR_IRQ_MASK 6'h39
`define DCR_ADDR_CONTROL 6'h3A

// status, mask and control bit positions
`define DCR_ST_DONE 0
`define DCR_ST_REJECT 1
`define DCR_ST_BUSY 2
`define DCR_CTL_START 0

// decoder selection codes
`define DCR_DEC_NONE 8'h00
`define DCR_DEC_VIT_12 8'h01
`define DCR_DEC_VIT_34 8'h03
`define DCR_DEC_VIT_78 8'h05
`define DCR_DEC_SEQ_12 8'h07
`define DCR_DEC_SEQ_34 8'h09
`define DCR_DEC_SEQ_78 8'h0B
`define DCR_DEC_TRELLIS 8'h0E

// interleaver depths
`define DCR_DEPTH_4 8'h04
`define DCR_DEPTH_8 8'h08

// descrambler type codes
`define DCR_DSC_V35_LAST 8'h04
`define DCR_DSC_RS 8'h07
`define DCR_DSC_V35_RS 8'h08

// largest legal codes of small fields
`define DCR_MAX_FLAG 8'h01
`define DCR_MAX_BUF_CLK 8'h03

// used bits of alarm masks; spare bits stay zero
`define DCR_USE_MASK1 8'hFF
`define DCR_USE_MASK2 8'h3F
`define DCR_USE_MASK3 8'hFF
`define DCR_USE_MASK4 8'h0F
`define DCR_USE_COMMON 8'h7F

// reset values
`define DCR_RST_BYTE 8'h00
`define DCR_RST_DEPTH 8'h04
`define DCR_RST_MASK 8'h00

`endif

/* File: dcr_host.sv */
`timescale 1ns/1ps
module dcr_host (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // response stream
  input wire [7:0] resp_data,
  input wire resp_valid,
  input wire resp_last,
  output logic resp_ready,
  // bench asks for a slow host
  input wire stall
);
  logic [7:0] got [0:63];
  int idx;
  int frames;
  // takes bytes; a frame opens with its count byte at index 0
  always @(posedge mclk) begin
    if (!reset_n) begin
      resp_ready <= 1'b0;
      idx <= 0;
      frames <= 0;
    end else begin
      resp_ready <= stall ? ~resp_ready : 1'b1;
      if (resp_valid && resp_ready) begin
        got[idx] <= resp_data;
        idx <= resp_last ? 0 : idx + 1;
        if (resp_last) frames <= frames + 1;
      end
    end
  end
endmodule // dcr_host

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, query_req = 0, stall = 0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata, resp_data, decoder_sel;
  wire resp_valid, resp_last, resp_ready, rs_enable, descr_enable, spectrum_inv, test_mode, irq;
  int n_fail = 0;
  int checked = 0;
  logic [7:0] rec [0:50];
  logic [7:0] codes [0:7] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h0E};
  // address, written value, value read back
  logic [23:0] tv [0:24] = '{24'h000E0E, 24'h00020E,
    24'h050808, 24'h050508, 24'h010101, 24'h060200, 24'h070101,
    24'h080404, 24'h080707, 24'h080507, 24'h080808,
    24'h090101, 24'h0F0200, 24'h0A1212, 24'h0D3434,
    24'h0E0303, 24'h0E0403, 24'h100101, 24'h11FFFF, 24'h12FF3F,
    24'h13A5A5, 24'h14FF0F, 24'h15FF7F, 24'h165500, 24'h170606};
  dcr_config_record dut (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .query_req(query_req), .resp_data(resp_data), .resp_valid(resp_valid),
    .resp_last(resp_last), .resp_ready(resp_ready), .decoder_sel(decoder_sel),
    .rs_enable(rs_enable), .descr_enable(descr_enable), .spectrum_inv(spectrum_inv),
    .test_mode(test_mode), .irq(irq));
  dcr_host host (.mclk(mclk), .reset_n(reset_n), .resp_data(resp_data),
    .resp_valid(resp_valid), .resp_last(resp_last), .resp_ready(resp_ready), .stall(stall));
  // clock
  initial forever #20 mclk = ~mclk;
  // byte compare
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data sampled in the following cycle
  task rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, exp);
  endtask
  // verdict
  task test_done;
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog
  initial begin
    #400000;
    n_fail++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (rec[i]) rec[i] = (i == 5) ? 8'h04 : 8'h00;
    for (int a = 0; a < 51; a++) rd(a[5:0], rec[a]);
    rd(6'h3F, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      wr(6'h00, codes[i]);
      @(posedge mclk);
      @(negedge mclk);
      chk(decoder_sel, codes[i]);
    end
    $display("test decoder codes done");
    for (int i = 0; i < 25; i++) begin
      wr(tv[i][21:16], tv[i][15:8]);
      rd(tv[i][21:16], tv[i][7:0]);
      rec[tv[i][21:16]] = tv[i][7:0];
    end
    chk({4'h0, rs_enable, descr_enable, spectrum_inv, test_mode}, 8'h0F);
    $display("test field codes done");
    rd(6'h38, 8'h02);
    wr(6'h39, 8'h03);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({7'h00, irq}, 8'h01);
    wr(6'h38, 8'h02);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({7'h00, irq}, 8'h00);
    $display("test interrupt done");
    for (int i = 0; i < 24; i++) begin
      wr(6'h18 + i[5:0], 8'h41 + i[7:0]);
      rec[24 + i] = 8'h41 + i[7:0];
    end
    for (int r = 0; r < 2; r++) begin
      @(posedge mclk);
      stall <= (r == 0);
      if (r == 0) begin
        query_req <= 1'b1;
        @(posedge mclk);
        query_req <= 1'b0;
      end else
        wr(6'h3A, 8'h01);
      wr(6'h17, 8'h09);
      for (int k = 0; k < 400 && host.frames == r; k++) @(posedge mclk);
      chk(host.got[0], 8'h33);
      for (int i = 0; i < 51; i++) chk(host.got[i + 1], rec[i]);
      rd(6'h17, 8'h06);
      rd(6'h38, 8'h03);
      wr(6'h38, 8'h03);
      $display("test response %0d done", r);
    end
    test_done;
  end
endmodule // tb_top
